// >>> verilog/rx_seq_cfg.svh
// Encodings, reset values and timing counts of the receive restart and mode sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef RX_SEQ_CFG_SVH
`define RX_SEQ_CFG_SVH

`define RSQ_TRIG_NONE      3'h0
`define RSQ_TRIG_RSSI      3'h1
`define RSQ_TRIG_PRE       3'h6
`define RSQ_TRIG_BOTH      3'h7

`define RSQ_AR_OFF         2'h0
`define RSQ_AR_DELAY       2'h1
`define RSQ_AR_RELOCK      2'h2

`define RSQ_MODE_SLEEP     3'h0
`define RSQ_MODE_STANDBY   3'h1
`define RSQ_MODE_FS_TX     3'h2
`define RSQ_MODE_TX        3'h3
`define RSQ_MODE_FS_RX     3'h4
`define RSQ_MODE_RX        3'h5
`define RSQ_MODE_RST       `RSQ_MODE_SLEEP

`define RSQ_CLK_MHZ        100
`define RSQ_DELAY_UNIT_NS  1000
`define RSQ_DELAY_UNIT_CYC ((`RSQ_DELAY_UNIT_NS * `RSQ_CLK_MHZ + 999) / 1000)
`define RSQ_RELOCK_NS      40000
`define RSQ_RELOCK_CYC     ((`RSQ_RELOCK_NS * `RSQ_CLK_MHZ + 999) / 1000)
`define RSQ_DLY_W          16
`define RSQ_GAIN_RST       3'h1

`endif

// >>> verilog/rx_seq_pkg.sv
// Types shared by the receive restart and mode sequencer files.
// Assumes the constants header is compiled alongside.
package rx_seq_pkg;

  typedef enum logic [2:0] {
    seq_halted_state,
    lowpower_choice_state,
    idle_state,
    transmit_state,
    receive_state,
    packet_held_state,
    receive_timeout_state
  } seq_state_t;

  typedef struct packed {
    logic       gain_auto_enable;
    logic       freq_correct_auto_enable;
    logic [2:0] receive_trigger_select;
    logic [2:0] amplifier_gain_select;
    logic [1:0] auto_restart_select;
    logic       collision_restart_enable;
    logic [7:0] collision_level_threshold;
    logic [7:0] inter_packet_delay;
  } rx_cfg_t;

  typedef struct packed {
    logic idle_lowpower_select;
    logic lowpower_select;
    logic from_idle_rx;
    logic from_tx_rx;
  } seq_cfg_t;

  typedef struct packed {
    logic rx_restart_no_relock;
    logic rx_restart_with_relock;
    logic seq_launch_bit;
    logic seq_stop_bit;
  } cmd_t;

  typedef struct packed {
    logic signal_level_irq;
    logic preamble_found_irq;
    logic signal_level_timeout;
    logic preamble_wait_timeout;
    logic sync_wait_timeout;
    logic payload_complete_irq;
    logic fifo_empty;
    logic packet_sent_irq;
    logic timer_one_irq;
    logic timer_two_irq;
  } evt_t;

endpackage

// >>> verilog/rx_restart_delay.sv
// Down-counter that times the pause before an automatic receiver restart.
// Assumes i_load is nonzero whenever i_start pulses.
`timescale 1ns/1ns
`default_nettype none
`include "rx_seq_cfg.svh"

module rx_restart_delay (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_ce,
  input  wire logic                   i_start,
  input  wire logic                   i_clear,
  input  wire logic [`RSQ_DLY_W-1:0]  i_load,
  output logic                        o_busy,
  output logic                        o_done
);

  logic [`RSQ_DLY_W-1:0] count_reg;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
    end else if (i_ce) begin
      o_done <= 1'b0;
      if (i_clear) begin
        o_busy    <= 1'b0;
        count_reg <= '0;
      end else if (i_start) begin
        o_busy    <= 1'b1;
        count_reg <= i_load;
      end else if (o_busy) begin
        if (count_reg == `RSQ_DLY_W'(1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        count_reg <= count_reg - `RSQ_DLY_W'(1);
      end
    end
  end

endmodule // rx_restart_delay

`default_nettype wire

// >>> verilog/rx_restart_and_mode_sequencer.sv
// Receiver startup correction, receiver restart and top-level mode sequencer.
// Assumes commands and events come from logic on i_core_clk, one-cycle pulses.
//
// Summary of operation
// - Rerun gain/frequency correction on every receiver start
// - Trigger select picks the correction launch event
// - Gain correction if enabled, frequency if both
// - Gain auto off: use manual gain field
// - Restart command ignored unless mode settled
// - Auto-restart mode 00: no delay-timed restart after a payload
// - Mode 01: restart after delay once emptied
// - Mode 10: same plus synthesizer lock delay
// - Collision enable: restart on sudden level rise
// - Collision threshold sets rise in 1 dB
// - Launch from Sleep/Standby, remember initial mode
// - Stop bit forces sequencer off immediately
// - Off from low-power choice restores initial mode
// - Idle holds low-power mode until timer one
// - Transmit state transmits, receive state receives
// - Packet-held state keeps receiver on
// - Low-power choice is transient: off or idle
// - Any receive timeout enters receive-timeout state
// - Idle select: 0 Standby, 1 Sleep
// - Low-power select: 0 off, 1 idle
`timescale 1ns/1ns
`default_nettype none
`include "rx_seq_cfg.svh"

module rx_restart_and_mode_sequencer (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  input  wire rx_seq_pkg::rx_cfg_t  i_rx_cfg,
  input  wire rx_seq_pkg::seq_cfg_t i_seq_cfg,
  input  wire rx_seq_pkg::cmd_t     i_cmd,
  input  wire rx_seq_pkg::evt_t     i_evt,
  input  wire logic                 i_mode_settled_flag,
  input  wire logic [2:0]           i_host_mode,
  input  wire logic                 i_host_mode_wr,
  input  wire logic [7:0]           i_rssi_level,
  input  wire logic [2:0]           i_agc_gain_level,
  output logic [2:0]                o_chip_mode,
  output logic                      o_agc_run,
  output logic                      o_afc_run,
  output logic [2:0]                o_lna_gain,
  output logic                      o_gain_manual,
  output logic                      o_rx_restart,
  output logic                      o_relock,
  output logic                      o_collision,
  output rx_seq_pkg::seq_state_t    o_seq_state,
  output rx_seq_pkg::cmd_t          o_cmd_pending
);

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? 8'hFF : s[7:0];
  endfunction

  function automatic logic is_low_power(input logic [2:0] m);
    is_low_power = (m == `RSQ_MODE_SLEEP) || (m == `RSQ_MODE_STANDBY);
  endfunction

  rx_seq_pkg::seq_state_t seq_next;
  logic [2:0]  mode_next;
  logic [2:0]  init_mode_reg;
  logic        ret_init_reg;
  logic        armed_reg;
  logic        rssi_seen_reg;
  logic        pre_seen_reg;
  logic        base_valid_reg;
  logic [7:0]  rssi_ref_reg;
  logic        wait_empty_reg;
  logic        rx_mode;
  logic        rx_start;
  logic        trig_hit;
  logic        base_take;
  logic        host_ok;
  logic        coll_hit;
  logic        auto_hit;
  logic        seq_restart;
  logic        restart_fire;
  logic        relock_fire;
  logic        rx_timeout;
  logic        dly_start;
  logic        dly_done;
  logic [`RSQ_DLY_W-1:0] dly_load;

  assign rx_mode    = (o_chip_mode == `RSQ_MODE_RX);
  assign rx_timeout = i_evt.signal_level_timeout | i_evt.preamble_wait_timeout
                    | i_evt.sync_wait_timeout;

  // Command bits are latched one cycle, acted on, then read back as zero
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_pending <= '0;
    end else if (i_ce) begin
      o_cmd_pending <= i_cmd;
    end
  end

  // Restart sources
  always_comb begin
    host_ok = (o_cmd_pending.rx_restart_no_relock | o_cmd_pending.rx_restart_with_relock)
            & i_mode_settled_flag & rx_mode;
    coll_hit = i_rx_cfg.collision_restart_enable & rx_mode & base_valid_reg
             & (i_rssi_level > sat_add(rssi_ref_reg, i_rx_cfg.collision_level_threshold));
    auto_hit = dly_done & rx_mode;
    seq_restart = (o_seq_state == rx_seq_pkg::packet_held_state) & i_evt.fifo_empty;
    restart_fire = host_ok | coll_hit | auto_hit | seq_restart;
    relock_fire = (host_ok & o_cmd_pending.rx_restart_with_relock)
                | (auto_hit & (i_rx_cfg.auto_restart_select == `RSQ_AR_RELOCK));
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_restart <= 1'b0;
      o_relock     <= 1'b0;
      o_collision  <= 1'b0;
    end else if (i_ce) begin
      o_rx_restart <= restart_fire;
      o_relock     <= relock_fire;
      o_collision  <= coll_hit;
    end
  end

  // Auto-restart: wait for the FIFO to drain after a payload, then time the pause
  assign dly_start = wait_empty_reg & i_evt.fifo_empty & rx_mode;
  // Mode 10 always pays the extra lock time even if the frequency did not move
  assign dly_load = `RSQ_DLY_W'(i_rx_cfg.inter_packet_delay * `RSQ_DELAY_UNIT_CYC + 1)
                  + ((i_rx_cfg.auto_restart_select == `RSQ_AR_RELOCK)
                     ? `RSQ_DLY_W'(`RSQ_RELOCK_CYC) : `RSQ_DLY_W'(0));

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_empty_reg <= 1'b0;
    end else if (i_ce) begin
      if (i_evt.payload_complete_irq & rx_mode
          & ((i_rx_cfg.auto_restart_select == `RSQ_AR_DELAY)
          | (i_rx_cfg.auto_restart_select == `RSQ_AR_RELOCK))) begin
        wait_empty_reg <= 1'b1;
      end else if (dly_start | !rx_mode) begin
        wait_empty_reg <= 1'b0;
      end
    end
  end

  rx_restart_delay u_delay (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_start    (dly_start),
    .i_clear    (!rx_mode | restart_fire),
    .i_load     (dly_load),
    .o_busy     (),
    .o_done     (dly_done)
  );

  // Startup correction arming
  assign rx_start = ((mode_next == `RSQ_MODE_RX) & !rx_mode) | restart_fire;

  always_comb begin
    case (i_rx_cfg.receive_trigger_select)
      `RSQ_TRIG_RSSI: trig_hit = i_evt.signal_level_irq;
      `RSQ_TRIG_PRE:  trig_hit = i_evt.preamble_found_irq;
      `RSQ_TRIG_BOTH: trig_hit = (i_evt.signal_level_irq | rssi_seen_reg)
                               & (i_evt.preamble_found_irq | pre_seen_reg);
      default:        trig_hit = 1'b0;
    endcase
    base_take = armed_reg & rx_mode
              & (trig_hit | (i_rx_cfg.receive_trigger_select == `RSQ_TRIG_NONE));
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_reg     <= 1'b0;
      rssi_seen_reg <= 1'b0;
      pre_seen_reg  <= 1'b0;
    end else if (i_ce) begin
      if (rx_start) begin
        armed_reg     <= 1'b1;
        rssi_seen_reg <= 1'b0;
        pre_seen_reg  <= 1'b0;
      end else if (base_take) begin
        armed_reg <= 1'b0;
      end else begin
        rssi_seen_reg <= rssi_seen_reg | i_evt.signal_level_irq;
        pre_seen_reg  <= pre_seen_reg | i_evt.preamble_found_irq;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_agc_run <= 1'b0;
      o_afc_run <= 1'b0;
    end else if (i_ce) begin
      o_agc_run <= !rx_start & armed_reg & rx_mode & trig_hit
                 & i_rx_cfg.gain_auto_enable;
      o_afc_run <= !rx_start & armed_reg & rx_mode & trig_hit
                 & i_rx_cfg.gain_auto_enable & i_rx_cfg.freq_correct_auto_enable;
    end
  end

  // Collision baseline is the level seen when the correction trigger fires, or at once when no trigger is selected
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      base_valid_reg <= 1'b0;
      rssi_ref_reg   <= 8'h00;
    end else if (i_ce) begin
      if (rx_start) begin
        base_valid_reg <= 1'b0;
      end else if (base_take) begin
        base_valid_reg <= 1'b1;
        rssi_ref_reg   <= i_rssi_level;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lna_gain    <= `RSQ_GAIN_RST;
      o_gain_manual <= 1'b1;
    end else if (i_ce) begin
      o_gain_manual <= !i_rx_cfg.gain_auto_enable;
      o_lna_gain    <= i_rx_cfg.gain_auto_enable ? i_agc_gain_level
                                                 : i_rx_cfg.amplifier_gain_select;
    end
  end

  // Sequencer transitions
  always_comb begin
    seq_next = o_seq_state;
    case (o_seq_state)
      rx_seq_pkg::seq_halted_state: begin
        if (o_cmd_pending.seq_launch_bit & is_low_power(o_chip_mode)) begin
          seq_next = rx_seq_pkg::lowpower_choice_state;
        end
      end
      rx_seq_pkg::lowpower_choice_state: begin
        seq_next = i_seq_cfg.lowpower_select ? rx_seq_pkg::idle_state
                                             : rx_seq_pkg::seq_halted_state;
      end
      rx_seq_pkg::idle_state: begin
        if (i_evt.timer_one_irq) begin
          seq_next = i_seq_cfg.from_idle_rx ? rx_seq_pkg::receive_state
                                            : rx_seq_pkg::transmit_state;
        end
      end
      rx_seq_pkg::transmit_state: begin
        if (i_evt.packet_sent_irq) begin
          seq_next = i_seq_cfg.from_tx_rx ? rx_seq_pkg::receive_state
                                          : rx_seq_pkg::lowpower_choice_state;
        end
      end
      rx_seq_pkg::receive_state: begin
        if (rx_timeout) begin
          seq_next = rx_seq_pkg::receive_timeout_state;
        end else if (i_evt.payload_complete_irq) begin
          seq_next = rx_seq_pkg::packet_held_state;
        end else if (i_evt.timer_two_irq) begin
          seq_next = rx_seq_pkg::lowpower_choice_state;
        end
      end
      rx_seq_pkg::packet_held_state: begin
        if (i_evt.fifo_empty) begin
          seq_next = rx_seq_pkg::receive_state;
        end
      end
      rx_seq_pkg::receive_timeout_state: begin
        seq_next = rx_seq_pkg::lowpower_choice_state;
      end
      default: begin
        seq_next = rx_seq_pkg::seq_halted_state;
      end
    endcase
    // Stop overrides everything, including a launch in the same write
    if (o_cmd_pending.seq_stop_bit) begin
      seq_next = rx_seq_pkg::seq_halted_state;
    end
  end

  // Chip mode that follows the next sequencer state
  always_comb begin
    case (seq_next)
      rx_seq_pkg::seq_halted_state: begin
        if (o_seq_state == rx_seq_pkg::lowpower_choice_state
            && !o_cmd_pending.seq_stop_bit) begin
          mode_next = init_mode_reg;
        end else if (ret_init_reg && !i_host_mode_wr) begin
          mode_next = init_mode_reg;
        end else if (o_seq_state == rx_seq_pkg::seq_halted_state && !i_host_mode_wr) begin
          mode_next = o_chip_mode;
        end else begin
          mode_next = i_host_mode;
        end
      end
      rx_seq_pkg::lowpower_choice_state: mode_next = o_chip_mode;
      rx_seq_pkg::idle_state: begin
        mode_next = i_seq_cfg.idle_lowpower_select ? `RSQ_MODE_SLEEP
                                                   : `RSQ_MODE_STANDBY;
      end
      rx_seq_pkg::transmit_state: mode_next = `RSQ_MODE_TX;
      rx_seq_pkg::receive_state:  mode_next = `RSQ_MODE_RX;
      rx_seq_pkg::packet_held_state: mode_next = `RSQ_MODE_RX;
      rx_seq_pkg::receive_timeout_state: mode_next = `RSQ_MODE_RX;
      default: mode_next = `RSQ_MODE_RST;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seq_state <= rx_seq_pkg::seq_halted_state;
      o_chip_mode <= `RSQ_MODE_RST;
    end else if (i_ce) begin
      o_seq_state <= seq_next;
      o_chip_mode <= mode_next;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      init_mode_reg <= `RSQ_MODE_RST;
      ret_init_reg  <= 1'b0;
    end else if (i_ce) begin
      if (o_seq_state == rx_seq_pkg::seq_halted_state
          && seq_next == rx_seq_pkg::lowpower_choice_state) begin
        init_mode_reg <= o_chip_mode;
      end
      if (o_seq_state == rx_seq_pkg::lowpower_choice_state
          && seq_next == rx_seq_pkg::seq_halted_state) begin
        ret_init_reg <= 1'b1;
      end else if (i_host_mode_wr || o_cmd_pending.seq_stop_bit) begin
        ret_init_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst || !i_ce);

  sequence s_choice_to_off;
    (o_seq_state == rx_seq_pkg::lowpower_choice_state) && !i_seq_cfg.lowpower_select
      && !o_cmd_pending.seq_stop_bit;
  endsequence

  sequence s_idle_no_timer;
    (o_seq_state == rx_seq_pkg::idle_state) && !i_evt.timer_one_irq
      && !o_cmd_pending.seq_stop_bit;
  endsequence

  a_restart_needs_settled: assert property (
    ((o_cmd_pending.rx_restart_no_relock || o_cmd_pending.rx_restart_with_relock)
     && !i_mode_settled_flag && !coll_hit && !auto_hit
     && !seq_restart) |=> !o_rx_restart)
    else $error("Restart taken while mode not settled");

  a_trigger_launches_gain: assert property (
    (armed_reg && rx_mode && trig_hit && !rx_start && i_rx_cfg.gain_auto_enable)
      |=> o_agc_run ##1 !o_agc_run)
    else $error("Gain correction not launched once on trigger");

  a_freq_needs_gain: assert property (
    o_afc_run |-> o_agc_run && $past(i_rx_cfg.freq_correct_auto_enable))
    else $error("Frequency correction without gain correction");

  a_no_trigger_quiet: assert property (
    o_agc_run |-> $past(i_rx_cfg.receive_trigger_select) != `RSQ_TRIG_NONE)
    else $error("Correction ran with no trigger selected");

  a_manual_gain_used: assert property (
    !i_rx_cfg.gain_auto_enable |=> o_gain_manual
      && o_lna_gain == $past(i_rx_cfg.amplifier_gain_select))
    else $error("Manual gain not applied");

  a_stop_forces_off: assert property (
    o_cmd_pending.seq_stop_bit |=> o_seq_state == rx_seq_pkg::seq_halted_state)
    else $error("Stop did not halt sequencer");

  a_launch_records_mode: assert property (
    (o_seq_state == rx_seq_pkg::seq_halted_state && o_cmd_pending.seq_launch_bit
     && !o_cmd_pending.seq_stop_bit && is_low_power(o_chip_mode))
      |=> o_seq_state == rx_seq_pkg::lowpower_choice_state
          && init_mode_reg == $past(o_chip_mode))
    else $error("Launch did not start or record mode");

  a_off_restores_mode: assert property (
    s_choice_to_off |=> o_seq_state == rx_seq_pkg::seq_halted_state
      && o_chip_mode == init_mode_reg)
    else $error("Initial mode not restored");

  a_idle_waits_timer: assert property (
    s_idle_no_timer ##1 s_idle_no_timer |=> o_seq_state == rx_seq_pkg::idle_state
      && is_low_power(o_chip_mode))
    else $error("Idle left without timer");

  a_choice_transient: assert property (
    o_seq_state == rx_seq_pkg::lowpower_choice_state
      |=> o_seq_state != rx_seq_pkg::lowpower_choice_state)
    else $error("Low-power choice not transient");

  a_timeout_entered: assert property (
    (o_seq_state == rx_seq_pkg::receive_state && rx_timeout && !o_cmd_pending.seq_stop_bit)
      |=> o_seq_state == rx_seq_pkg::receive_timeout_state)
    else $error("Receive timeout not entered");

  a_receive_state_rx: assert property (
    o_seq_state == rx_seq_pkg::receive_state |-> o_chip_mode == `RSQ_MODE_RX)
    else $error("Receiver off in receive state");

endmodule // rx_restart_and_mode_sequencer

`default_nettype wire

// >>> test/rx_host_model.sv
// Host controller model that issues one-shot command writes to the sequencer.
// Assumes the sequencer samples commands on the rising edge of i_core_clk.
`timescale 1ns/1ns
`default_nettype none

module rx_host_model (
  input  wire logic              i_core_clk,
  output var  rx_seq_pkg::cmd_t  o_cmd
);
  initial o_cmd = '0;

  // Relock choice follows the oscillator state, not a caller-supplied bit
  task automatic restart(input logic afc_on, input logic frf_changed);
    @(negedge i_core_clk);
    if (afc_on || frf_changed) begin
      o_cmd.rx_restart_with_relock = 1'b1;
    end else begin
      o_cmd.rx_restart_no_relock = 1'b1;
    end
    @(negedge i_core_clk);
    o_cmd = '0;
  endtask

  // Launch and stop go out in separate writes only
  task automatic seq(input logic launch);
    @(negedge i_core_clk);
    if (launch) begin
      o_cmd.seq_launch_bit = 1'b1;
    end else begin
      o_cmd.seq_stop_bit = 1'b1;
    end
    @(negedge i_core_clk);
    o_cmd = '0;
  endtask
endmodule // rx_host_model
`default_nettype wire

// >>> test/rx_restart_and_mode_sequencer_tb.sv
// Self-checking bench for the receive restart and mode sequencer.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ns
`default_nettype none

module rx_restart_and_mode_sequencer_tb;
  logic                   core_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   ce = 1'b1;
  rx_seq_pkg::rx_cfg_t    rx_cfg;
  rx_seq_pkg::seq_cfg_t   seq_cfg;
  rx_seq_pkg::cmd_t       cmd;
  rx_seq_pkg::evt_t       evt = '0;
  logic                   settled = 1'b1;
  logic [2:0]             host_mode = 3'h1;
  logic                   host_mode_wr = 1'b0;
  logic [7:0]             rssi = 8'h20;
  logic [2:0]             agc_gain = 3'h6;
  logic [2:0]             chip_mode;
  logic                   agc_run;
  logic                   afc_run;
  logic [2:0]             lna_gain;
  logic                   gain_manual;
  logic                   rx_restart;
  logic                   relock;
  logic                   collision;
  rx_seq_pkg::seq_state_t state;
  rx_seq_pkg::cmd_t       pending;
  logic [7:0]             n_agc = 8'h0, n_afc = 8'h0, n_rst = 8'h0, n_rel = 8'h0, n_col = 8'h0;
  int                     n_errors = 0;
  int                     n_tests = 0;

  always #5 core_clk = ~core_clk;

  rx_host_model host (.i_core_clk(core_clk), .o_cmd(cmd));

  rx_restart_and_mode_sequencer uut (
    .i_core_clk(core_clk), .i_rst(rst), .i_ce(ce), .i_rx_cfg(rx_cfg), .i_seq_cfg(seq_cfg),
    .i_cmd(cmd), .i_evt(evt), .i_mode_settled_flag(settled), .i_host_mode(host_mode),
    .i_host_mode_wr(host_mode_wr), .i_rssi_level(rssi), .i_agc_gain_level(agc_gain),
    .o_chip_mode(chip_mode), .o_agc_run(agc_run), .o_afc_run(afc_run), .o_lna_gain(lna_gain),
    .o_gain_manual(gain_manual), .o_rx_restart(rx_restart), .o_relock(relock),
    .o_collision(collision), .o_seq_state(state), .o_cmd_pending(pending));

  // Pulse counters let a missing or doubled pulse show up as a count mismatch
  always @(posedge core_clk) begin
    if (agc_run === 1'b1) n_agc <= n_agc + 8'h1;
    if (afc_run === 1'b1) n_afc <= n_afc + 8'h1;
    if (rx_restart === 1'b1) n_rst <= n_rst + 8'h1;
    if (relock === 1'b1) n_rel <= n_rel + 8'h1;
    if (collision === 1'b1) n_col <= n_col + 8'h1;
  end

  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(input logic [9:0] e);
    @(negedge core_clk);
    evt = e;
    @(negedge core_clk);
    evt = '0;
  endtask

  // One packet then a drained FIFO, with the auto-restart mode under test
  task automatic auto_pkt(input logic [1:0] m, input int n);
    @(negedge core_clk);
    rx_cfg.auto_restart_select = m;
    pulse(10'h010);
    pulse(10'h008);
    step(n);
  endtask

  // Polls every cycle so a one-cycle state is not missed
  task automatic wait_state(input rx_seq_pkg::seq_state_t s);
    int k;
    for (k = 0; k < 8 && state !== s; k++) step(1);
    n_tests++;
    if (state !== s) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, state, s);
      complete_run();
    end
  endtask

  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end

  initial begin
    rx_cfg = '0;
    rx_cfg.gain_auto_enable = 1'b1;
    rx_cfg.freq_correct_auto_enable = 1'b1;
    rx_cfg.receive_trigger_select = 3'h1;
    rx_cfg.amplifier_gain_select = 3'h5;
    rx_cfg.collision_level_threshold = 8'h0A;
    rx_cfg.inter_packet_delay = 8'h01;
    seq_cfg = '0;
    seq_cfg.from_idle_rx = 1'b1;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    chk(8'(chip_mode), 8'h00);
    chk(8'(lna_gain), 8'h01);
    chk(8'(state), 8'(rx_seq_pkg::seq_halted_state));
    @(negedge core_clk);
    host_mode_wr = 1'b1;
    @(negedge core_clk);
    host_mode_wr = 1'b0;
    step(1);
    chk(8'(chip_mode), 8'h01);
    host.seq(1'b1);
    chk(8'(pending), 8'h02);
    step(1);
    chk(8'(pending), 8'h00);
    chk(8'(state), 8'(rx_seq_pkg::lowpower_choice_state));
    step(1);
    chk(8'(state), 8'(rx_seq_pkg::seq_halted_state));
    chk(8'(chip_mode), 8'h01);
    seq_cfg.lowpower_select = 1'b1;
    seq_cfg.idle_lowpower_select = 1'b1;
    host.seq(1'b1);
    step(3);
    chk(8'(state), 8'(rx_seq_pkg::idle_state));
    chk(8'(chip_mode), 8'h00);
    pulse(10'h001);
    step(3);
    chk(8'(state), 8'(rx_seq_pkg::idle_state));
    pulse(10'h002);
    wait_state(rx_seq_pkg::receive_state);
    chk(8'(chip_mode), 8'h05);
    chk(8'(lna_gain), 8'h06);
    pulse(10'h100);
    step(3);
    chk(n_agc, 8'h00);
    pulse(10'h200);
    pulse(10'h200);
    step(3);
    chk(n_agc, 8'h01);
    chk(n_afc, 8'h01);
    settled = 1'b0;
    host.restart(1'b1, 1'b0);
    step(4);
    chk(n_rst, 8'h00);
    settled = 1'b1;
    host.restart(1'b1, 1'b0);
    step(4);
    chk(n_rst, 8'h01);
    chk(n_rel, 8'h01);
    rx_cfg.collision_restart_enable = 1'b1;
    pulse(10'h200);
    step(3);
    chk(n_agc, 8'h02);
    @(negedge core_clk);
    rssi = 8'h2A;
    step(4);
    chk(n_col, 8'h00);
    @(negedge core_clk);
    rssi = 8'h2B;
    step(4);
    chk(n_col, 8'h01);
    chk(n_rst, 8'h02);
    @(negedge core_clk);
    rx_cfg.collision_restart_enable = 1'b0;
    rx_cfg.freq_correct_auto_enable = 1'b0;
    rx_cfg.gain_auto_enable = 1'b0;
    rssi = 8'h20;
    host.restart(1'b0, 1'b0);
    step(4);
    chk(n_rst, 8'h03);
    chk(n_rel, 8'h01);
    pulse(10'h200);
    step(3);
    chk(n_agc, 8'h02);
    chk(8'(gain_manual), 8'h01);
    chk(8'(lna_gain), 8'h05);
    pulse(10'h010);
    chk(8'(state), 8'(rx_seq_pkg::packet_held_state));
    chk(8'(chip_mode), 8'h05);
    pulse(10'h008);
    step(2);
    chk(8'(state), 8'(rx_seq_pkg::receive_state));
    chk(n_rst, 8'h04);
    pulse(10'h020);
    wait_state(rx_seq_pkg::receive_timeout_state);
    wait_state(rx_seq_pkg::idle_state);
    host.seq(1'b0);
    step(2);
    chk(8'(state), 8'(rx_seq_pkg::seq_halted_state));
    @(negedge core_clk);
    host_mode = 3'h5;
    host_mode_wr = 1'b1;
    @(negedge core_clk);
    host_mode_wr = 1'b0;
    auto_pkt(2'h0, 300);
    chk(n_rst, 8'h04);
    auto_pkt(2'h1, 300);
    chk(n_rst, 8'h05);
    chk(n_rel, 8'h01);
    auto_pkt(2'h2, 300);
    chk(n_rst, 8'h05);
    step(4000);
    chk(n_rst, 8'h06);
    chk(n_rel, 8'h02);
    @(negedge core_clk);
    rx_cfg.gain_auto_enable = 1'b1;
    rx_cfg.receive_trigger_select = 3'h7;
    pulse(10'h100);
    step(2);
    chk(n_agc, 8'h02);
    pulse(10'h200);
    step(2);
    chk(n_agc, 8'h03);
    // A frozen block must drop a command written while the enable is low
    @(negedge core_clk);
    ce = 1'b0;
    host.restart(1'b0, 1'b0);
    step(3);
    chk(n_rst, 8'h06);
    chk(8'(pending), 8'h00);
    @(negedge core_clk);
    ce = 1'b1;
    rx_cfg.receive_trigger_select = 3'h6;
    host.restart(1'b0, 1'b0);
    step(3);
    chk(n_rst, 8'h07);
    pulse(10'h100);
    step(2);
    chk(n_agc, 8'h04);
    complete_run();
  end
endmodule // rx_restart_and_mode_sequencer_tb
`default_nettype wire
